/* File: design/sbp_consts.vh */
`ifndef SBP_CONSTS_VH
`define SBP_CONSTS_VH
// How it works
// - the second parameter header holds pointer bytes 40h, 03h, 00h, placing the basic table at 0340h.
// - the top byte of that header's identifier reads FFh, marking a standard-defined parameter.
// - table byte 00h reads E5h: unused 111b, volatile-write bits 00b, big program buffer 1, uniform 4 KB erase 01b.
// - table byte 01h reads 20h, the uniform 4 KB erase instruction, which the device accepts.
// - table byte 02h reads FBh: read feature flags set, unused bit 23 set, address-byte field 01b.
// - table byte 03h is unused and reads FFh.
// - table bytes 04h..07h give zero-based density FFh, FFh, FFh, 03h, low byte first.
// - table byte 08h reads 48h (mode 010b, dummy 01000b) and byte 09h gives the quad io read code EBh.
// - table byte 0Ah reads 08h (mode 000b, dummy 01000b) and byte 0Bh gives the quad output read code 6Bh.
// - table byte 0Ch reads 08h (mode 000b, dummy 01000b) for the dual output read.
// - table byte 0Dh gives the dual output read code 3Bh.

// apb map, byte addresses
`define SBP_ADDR_CTRL     12'h000
`define SBP_ADDR_STATUS   12'h004
`define SBP_ADDR_INDEX    12'h008
`define SBP_ADDR_DATA     12'h00c
`define SBP_ADDR_DWORD    12'h010
`define SBP_ADDR_WRCNT    12'h014
// control fields
`define SBP_CTRL_AUTOINC  0
`define SBP_CTRL_RESET    2'h1
// status fields
`define SBP_STAT_HIT      0
`define SBP_STAT_WRIGN    1
// discoverable space layout
`define SBP_HDR1_PTR0     12'h014
`define SBP_HDR1_PTR1     12'h015
`define SBP_HDR1_PTR2     12'h016
`define SBP_HDR1_IDMSB    12'h017
`define SBP_TABLE_BASE    12'h340
`define SBP_TABLE_LEN     12'h00e
`define SBP_FILL_BYTE     8'hff
// byte values
`define SBP_V_PTR0        8'h40
`define SBP_V_PTR1        8'h03
`define SBP_V_PTR2        8'h00
`define SBP_V_IDMSB       8'hff
`define SBP_V_B00         8'he5
`define SBP_V_ERASE4K     8'h20
`define SBP_V_B02         8'hfb
`define SBP_V_B03         8'hff
`define SBP_V_DENS0       8'hff
`define SBP_V_DENS1       8'hff
`define SBP_V_DENS2       8'hff
`define SBP_V_DENS3       8'h03
`define SBP_V_QUAD_IO_READ_CYC  8'h48
`define SBP_V_QUAD_IO_READ_CODE 8'heb
`define SBP_V_QO_CYC      8'h08
`define SBP_V_QO_CODE     8'h6b
`define SBP_V_DO_CYC      8'h08
`define SBP_V_DO_CODE     8'h3b
`endif

/* File: design/sbp_dword.v */
`timescale 1ns/1ps
// packs four table bytes into a dword, low byte first
module sbp_dword
(
    input  wire        clk_in,
    input  wire        reset_in,
    input  wire        start_in,
    input  wire [7:0]  byte_in,
    output reg  [1:0]  lane_out,
    output reg         busy_out,
    output reg         done_out,
    output reg  [31:0] word_out
);
    reg [2:0] cnt_reg;

    // lane 0 address is presented on start; bytes return one cycle later
    always @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            cnt_reg  <= 3'h0;
            lane_out <= 2'h0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            word_out <= 32'h0000_0000;
        end
        else
        begin
            done_out <= 1'b0;
            if (start_in && !busy_out)
            begin
                busy_out <= 1'b1;
                lane_out <= 2'h0;
                cnt_reg  <= 3'h0;
            end
            else if (busy_out)
            begin
                cnt_reg  <= cnt_reg + 3'h1;
                lane_out <= lane_out + 2'h1;
                if (cnt_reg != 3'h0)
                    word_out <= {byte_in, word_out[31:8]}; // little endian
                if (cnt_reg == 3'h4)
                begin
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                end
            end
        end
    end
endmodule

/* File: design/sbp_rom.v */
`timescale 1ns/1ps
`include "sbp_consts.vh"
// fixed byte lookup over the discoverable space, registered read
module sbp_rom
(
    input  wire        clk_in,
    input  wire        reset_in,
    input  wire [11:0] addr_in,
    output reg  [7:0]  data_out,
    output reg         hit_out
);
    reg  [7:0]  byte_next;
    reg         hit_next;
    wire [11:0] rel = addr_in - `SBP_TABLE_BASE;

    // constant decode, no write path exists
    always @*
    begin
        byte_next = `SBP_FILL_BYTE;
        hit_next  = 1'b1;
        if (addr_in == `SBP_HDR1_PTR0)
            byte_next = `SBP_V_PTR0;
        else if (addr_in == `SBP_HDR1_PTR1)
            byte_next = `SBP_V_PTR1;
        else if (addr_in == `SBP_HDR1_PTR2)
            byte_next = `SBP_V_PTR2;
        else if (addr_in == `SBP_HDR1_IDMSB)
            byte_next = `SBP_V_IDMSB;
        else if (addr_in >= `SBP_TABLE_BASE && rel < `SBP_TABLE_LEN)
        begin
            case (rel[3:0])
                4'h0:    byte_next = `SBP_V_B00;
                4'h1:    byte_next = `SBP_V_ERASE4K;
                4'h2:    byte_next = `SBP_V_B02;
                4'h3:    byte_next = `SBP_V_B03;
                4'h4:    byte_next = `SBP_V_DENS0;
                4'h5:    byte_next = `SBP_V_DENS1;
                4'h6:    byte_next = `SBP_V_DENS2;
                4'h7:    byte_next = `SBP_V_DENS3;
                4'h8:    byte_next = `SBP_V_QUAD_IO_READ_CYC;
                4'h9:    byte_next = `SBP_V_QUAD_IO_READ_CODE;
                4'ha:    byte_next = `SBP_V_QO_CYC;
                4'hb:    byte_next = `SBP_V_QO_CODE;
                4'hc:    byte_next = `SBP_V_DO_CYC;
                4'hd:    byte_next = `SBP_V_DO_CODE;
                default: byte_next = `SBP_FILL_BYTE;
            endcase
        end
        else
            hit_next = 1'b0;
    end

    // read data from a register
    always @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            data_out <= 8'h00;
            hit_out  <= 1'b0;
        end
        else
        begin
            data_out <= byte_next;
            hit_out  <= hit_next;
        end
    end
endmodule

/* File: design/sbp_top.v */
`timescale 1ns/1ps
`include "sbp_consts.vh"
// apb slave giving software read access to the discoverable parameter table
module sbp_top
(
    input  wire        clk_in,
    input  wire        reset_in,
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [11:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out
);
    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_DONE = 3'b100;

    reg  [2:0]  state_reg;
    reg  [11:0] index_reg;
    reg         autoinc_reg;
    reg         wrign_reg;
    reg  [15:0] wrcnt_reg;
    reg         dw_start_reg;
    reg  [11:0] rom_addr;
    wire [7:0]  rom_byte;
    wire        rom_hit;
    wire [1:0]  dw_lane;
    wire        dw_busy;
    wire        dw_done;
    wire [31:0] dw_word;

    wire setup  = psel_in && !penable_in;

    // rom address: dword gather walks lanes, else the byte index
    always @*
    begin
        if (dw_busy)
            rom_addr = {index_reg[11:2], dw_lane};
        else
            rom_addr = index_reg;
    end

    sbp_rom u_rom
    (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .addr_in  (rom_addr),
        .data_out (rom_byte),
        .hit_out  (rom_hit)
    );

    sbp_dword u_dword
    (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .start_in (dw_start_reg),
        .byte_in  (rom_byte),
        .lane_out (dw_lane),
        .busy_out (dw_busy),
        .done_out (dw_done),
        .word_out (dw_word)
    );

    // decoded address check, used for writes and reads
    function known_addr;
        input [11:0] a;
        begin
            known_addr = (a == `SBP_ADDR_CTRL) || (a == `SBP_ADDR_STATUS) ||
                         (a == `SBP_ADDR_INDEX) || (a == `SBP_ADDR_DATA) ||
                         (a == `SBP_ADDR_DWORD) || (a == `SBP_ADDR_WRCNT);
        end
    endfunction

    // apb sequencing; dword reads wait for the gather
    always @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state_reg    <= ST_IDLE;
            index_reg    <= 12'h000;
            autoinc_reg  <= 1'b0;
            wrign_reg    <= 1'b0;
            wrcnt_reg    <= 16'h0000;
            dw_start_reg <= 1'b0;
            prdata_out   <= 32'h0000_0000;
            pready_out   <= 1'b0;
            pslverr_out  <= 1'b0;
        end
        else
        begin
            dw_start_reg <= 1'b0;
            pready_out   <= 1'b0;
            pslverr_out  <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (setup)
                    begin
                        if (!pwrite_in && paddr_in == `SBP_ADDR_DWORD)
                        begin
                            dw_start_reg <= 1'b1;
                            state_reg    <= ST_WAIT;
                        end
                        else
                            state_reg <= ST_DONE;
                    end
                end
                ST_WAIT:
                begin
                    if (dw_done)
                    begin
                        prdata_out <= dw_word;
                        pready_out <= 1'b1;
                        state_reg  <= ST_IDLE;
                    end
                end
                ST_DONE:
                begin
                    // rom byte for index_reg is valid by now
                    pready_out  <= 1'b1;
                    pslverr_out <= !known_addr(paddr_in);
                    state_reg   <= ST_IDLE;
                    prdata_out  <= 32'h0000_0000;
                    if (pwrite_in)
                    begin
                        if (paddr_in == `SBP_ADDR_CTRL)
                            autoinc_reg <= pwdata_in[`SBP_CTRL_AUTOINC];
                        else if (paddr_in == `SBP_ADDR_INDEX)
                            index_reg <= pwdata_in[11:0];
                        else if (paddr_in == `SBP_ADDR_STATUS)
                            wrign_reg <= wrign_reg & ~pwdata_in[`SBP_STAT_WRIGN];
                        else if (paddr_in == `SBP_ADDR_DATA || paddr_in == `SBP_ADDR_DWORD)
                        begin
                            wrign_reg <= 1'b1;                   // table writes dropped
                            wrcnt_reg <= wrcnt_reg + 16'h0001;
                        end
                    end
                    else
                    begin
                        if (paddr_in == `SBP_ADDR_CTRL)
                            prdata_out <= {31'h0, autoinc_reg};
                        else if (paddr_in == `SBP_ADDR_STATUS)
                            prdata_out <= {30'h0, wrign_reg, rom_hit};
                        else if (paddr_in == `SBP_ADDR_INDEX)
                            prdata_out <= {20'h0, index_reg};
                        else if (paddr_in == `SBP_ADDR_DATA)
                        begin
                            prdata_out <= {24'h0, rom_byte};     // fixed byte per address
                            if (autoinc_reg)
                                index_reg <= index_reg + 12'h001;
                        end
                        else if (paddr_in == `SBP_ADDR_WRCNT)
                            prdata_out <= {16'h0, wrcnt_reg};
                    end
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule

/* File: dv/sbp_apb_host.sv */
`timescale 1ns/1ps
// apb host model, one transfer at a time
module sbp_apb_host
(
    input  wire        clk_in,
    input  wire [31:0] prdata_in,
    input  wire        pready_in,
    input  wire        pslverr_in,
    output reg         psel_out,
    output reg         penable_out,
    output reg         pwrite_out,
    output reg  [11:0] paddr_out,
    output reg  [31:0] pwdata_out
);
    // idle bus at time zero
    initial
    begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 12'h000;
        pwdata_out = 32'h0;
    end
    // setup, access until ready, then release with scrambled lines
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
        begin
            @(posedge clk_in);
            psel_out <= 1'b1;
            pwrite_out <= w;
            paddr_out <= a;
            pwdata_out <= d;
            @(posedge clk_in);
            penable_out <= 1'b1;
            do @(posedge clk_in); while (pready_in !== 1'b1);
            q = prdata_in;
            e = pslverr_in;
            psel_out <= 1'b0;
            penable_out <= 1'b0;
            paddr_out <= ~a;
            pwdata_out <= ~d;
        end
    endtask
endmodule

/* File: dv/sbp_checker.sv */
`timescale 1ns/1ps
// watches the apb port of the parameter table slave
module sbp_checker
(
    input wire        clk_in,
    input wire        reset_in,
    input wire        psel_in,
    input wire        penable_in,
    input wire        pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire [31:0] prdata_out,
    input wire        pready_out,
    input wire        pslverr_out
);
    reg  [11:0] idx_reg;
    reg         inc_reg;
    wire        done = pready_out && psel_in && penable_in;
    wire        dw_rd = done && !pwrite_in && paddr_in == 12'h010;
    wire        setup = psel_in && !penable_in;
    wire        dw_setup = setup && !pwrite_in && paddr_in == 12'h010;
    wire        unmapped = paddr_in > 12'h014 || paddr_in[1:0] != 2'h0;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // mirror of the slave's index, autoincrement included
    always @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            idx_reg <= 12'h000;
            inc_reg <= 1'b0;
        end
        else if (done && pwrite_in && paddr_in == 12'h008)
            idx_reg <= pwdata_in[11:0];
        else if (done && pwrite_in && paddr_in == 12'h000)
            inc_reg <= pwdata_in[0];
        else if (done && !pwrite_in && paddr_in == 12'h00c && inc_reg)
            idx_reg <= idx_reg + 12'h001;
    end
    AST_READY_IN_ACCESS: assert property (pready_out |-> psel_in && penable_in)
        else $error("ready outside access");
    AST_ANSWER_BOUND: assert property (setup && !dw_setup |-> ##2 pready_out)
        else $error("no answer in time");
    AST_ANSWER_DWORD: assert property (dw_setup |-> ##8 pready_out)
        else $error("no dword answer in time");
    AST_ERR_UNMAPPED: assert property (done && unmapped |-> pslverr_out && prdata_out == 32'h0)
        else $error("unmapped not refused");
    AST_ERR_ONLY_UNMAPPED: assert property (pslverr_out |-> pready_out && unmapped)
        else $error("stray slave error");
    AST_BYTE_WIDTH: assert property (done && !pwrite_in && paddr_in == 12'h00c |-> prdata_out[31:8] == 24'h0)
        else $error("byte read too wide");
    AST_DW_FIRST: assert property (dw_rd && idx_reg[11:2] == 10'h0d0 |-> prdata_out == 32'hfffb20e5)
        else $error("first dword wrong");
    AST_DW_DENSITY: assert property (dw_rd && idx_reg[11:2] == 10'h0d1 |-> prdata_out == 32'h03ffffff)
        else $error("density dword wrong");
    AST_DW_QUAD: assert property (dw_rd && idx_reg[11:2] == 10'h0d2 |-> prdata_out == 32'h6b08eb48)
        else $error("quad dword wrong");
    AST_DW_DUAL: assert property (dw_rd && idx_reg[11:2] == 10'h0d3 |-> prdata_out == 32'hffff3b08)
        else $error("dual dword wrong");
    AST_DW_HEADER: assert property (dw_rd && idx_reg[11:2] == 10'h005 |-> prdata_out == 32'hff000340)
        else $error("header dword wrong");
endmodule

/* File: dv/sbp_top_test.sv */
`timescale 1ns/1ps
`include "sbp_consts.vh"
module sbp_top_test;
    logic        clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int          failures = 0;
    int          n_compared = 0;
    logic [7:0]  tbl [0:15] = '{8'he5, 8'h20, 8'hfb, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03,
                                8'h48, 8'heb, 8'h08, 8'h6b, 8'h08, 8'h3b, 8'hff, 8'hff};
    logic [7:0]  hdr [0:3] = '{8'h40, 8'h03, 8'h00, 8'hff};
    always #5 clk_in = ~clk_in;
    sbp_top i_dut (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr));
    sbp_apb_host i_host (.clk_in(clk_in), .prdata_in(prdata), .pready_in(pready), .pslverr_in(pslverr),
        .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata));
    // compare and count
    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        begin
            n_compared++;
            if (g !== x)
            begin
                failures++;
                $display("unexpected %s expected %h seen %h", nm, x, g);
            end
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        i_host.xfer(1'b1, a, d, q, e);
    endtask
    // read, check data and the error flag
    task rchk(input string nm, input logic [11:0] a, input logic [31:0] x);
        begin
            i_host.xfer(1'b0, a, 32'h0, q, e);
            chk(nm, x, q);
            chk("slave error", {31'h0, a > `SBP_ADDR_WRCNT || a[1:0] != 2'h0}, {31'h0, e});
        end
    endtask
    task give_verdict;
        begin
            $display("compared %0d mismatches %0d", n_compared, failures);
            if (failures == 0 && n_compared > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    initial
    begin : main
        int i;
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        rchk("wrcnt reset", `SBP_ADDR_WRCNT, 32'h0);
        // header bytes by explicit index
        for (i = 0; i < 4; i++)
        begin
            wr(`SBP_ADDR_INDEX, 32'h014 + i);
            rchk("header byte", `SBP_ADDR_DATA, {24'h0, hdr[i]});
        end
        // no autoincrement while it is off; misaligned place refused
        rchk("index kept", `SBP_ADDR_INDEX, 32'h017);
        rchk("misaligned", 12'h006, 32'h0);
        // table bytes by autoincrement, past the end too
        wr(`SBP_ADDR_CTRL, 32'h1);
        wr(`SBP_ADDR_INDEX, 32'h340);
        for (i = 0; i < 16; i++)
            rchk("table byte", `SBP_ADDR_DATA, {24'h0, tbl[i]});
        // packed dwords, low byte first
        for (i = 0; i < 4; i++)
        begin
            wr(`SBP_ADDR_INDEX, 32'h340 + 4 * i);
            rchk("dword", `SBP_ADDR_DWORD, {tbl[4*i+3], tbl[4*i+2], tbl[4*i+1], tbl[4*i]});
        end
        wr(`SBP_ADDR_INDEX, 32'h014);
        rchk("header dword", `SBP_ADDR_DWORD, 32'hff000340);
        // writes to the table are dropped and counted
        wr(`SBP_ADDR_DATA, 32'h55);
        wr(`SBP_ADDR_DWORD, 32'h0);
        wr(`SBP_ADDR_INDEX, 32'h340);
        rchk("table after write", `SBP_ADDR_DATA, 32'he5);
        rchk("ignored count", `SBP_ADDR_WRCNT, 32'h2);
        i_host.xfer(1'b0, `SBP_ADDR_STATUS, 32'h0, q, e);
        chk("ignored flag", 32'h2, q & 32'h2);
        chk("hit flag", 32'h1, q & 32'h1);
        wr(`SBP_ADDR_STATUS, 32'h2);
        i_host.xfer(1'b0, `SBP_ADDR_STATUS, 32'h0, q, e);
        chk("flag cleared", 32'h0, q & 32'h2);
        // unmapped place refused without effect
        wr(12'h020, 32'hffffffff);
        rchk("unmapped", 12'h020, 32'h0);
        rchk("count kept", `SBP_ADDR_WRCNT, 32'h2);
        // index outside the defined bytes clears the hit flag
        wr(`SBP_ADDR_INDEX, 32'h100);
        rchk("miss status", `SBP_ADDR_STATUS, 32'h0);
        rchk("ctrl", `SBP_ADDR_CTRL, 32'h1);
        rchk("index", `SBP_ADDR_INDEX, 32'h100);
        give_verdict;
    end
    // watchdog
    initial
    begin
        #100000;
        failures++;
        give_verdict;
    end
endmodule
bind sbp_top sbp_checker i_chk (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out));
